// >>> cad_alu.sv
// Arithmetic unit: add, add with carry, subtract with borrow, inc, dec, mul, div, decimal adjust
`timescale 1ns/1ps
module cad_alu (
  input  wire cad_pkg::cad_alu_t sel_in,
  input  wire logic [7:0]        a_in,
  input  wire logic [7:0]        opd_in,
  input  wire logic              cy_in,
  input  wire logic              ac_in,
  output logic [7:0]             res_out,
  output logic [7:0]             hi_out,
  output logic                   cy_out,
  output logic                   ov_out,
  output logic                   ac_out
);
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [15:0] prod;
  logic [8:0]  da1;
  logic [8:0]  da2;
  logic        cin;

  assign cin  = (sel_in == cad_pkg::ALU_ADD) ? 1'b0 : cy_in;
  assign prod = a_in * opd_in;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    da1 = 9'h000;
    da2 = 9'h000;
    res_out = a_in;
    hi_out  = opd_in;
    cy_out  = cy_in;
    ov_out  = 1'b0;
    ac_out  = ac_in;
    case (sel_in)
      cad_pkg::ALU_ADD, cad_pkg::ALU_ADD_WITH_CARRY: begin
        sum = {1'b0, a_in} + {1'b0, opd_in} + {8'h00, cin}; // [RULE13]
        nib = {1'b0, a_in[3:0]} + {1'b0, opd_in[3:0]} + {4'h0, cin};
        res_out = sum[7:0];
        cy_out  = sum[8];
        ac_out  = nib[4];
        ov_out  = (a_in[7] == opd_in[7]) && (sum[7] != a_in[7]);
      end
      cad_pkg::ALU_SUBTRACT_WITH_BORROW: begin
        // Bit 8 of the wrapped difference is the borrow
        sum = {1'b0, a_in} - {1'b0, opd_in} - {8'h00, cin}; // [RULE14]
        nib = {1'b0, a_in[3:0]} - {1'b0, opd_in[3:0]} - {4'h0, cin};
        res_out = sum[7:0];
        cy_out  = sum[8];
        ac_out  = nib[4];
        ov_out  = (a_in[7] != opd_in[7]) && (sum[7] != a_in[7]);
      end
      cad_pkg::ALU_INC: res_out = a_in + 8'h01;
      cad_pkg::ALU_DEC: res_out = a_in - 8'h01;
      cad_pkg::ALU_MUL: begin
        res_out = prod[7:0];
        hi_out  = prod[15:8];
        cy_out  = 1'b0;
        ov_out  = |prod[15:8]; // [RULE10]
      end
      cad_pkg::ALU_DIV: begin
        cy_out = 1'b0;
        ov_out = (opd_in == 8'h00); // [RULE10]
        if (opd_in == 8'h00) begin
          // Divide by zero leaves both operands as they were
          res_out = a_in;
          hi_out  = opd_in;
        end else begin
          res_out = a_in / opd_in;
          hi_out  = a_in % opd_in;
        end
      end
      cad_pkg::ALU_DA: begin
        da1 = {1'b0, a_in} + (((a_in[3:0] > cad_pkg::BCD_MAX) || ac_in) ? cad_pkg::DA_LO : 9'h000);
        da2 = da1 + (((da1[7:4] > cad_pkg::BCD_MAX) || cy_in || da1[8]) ?
                     cad_pkg::DA_HI : 9'h000); // [RULE19]
        res_out = da2[7:0];
        cy_out  = cy_in | da1[8] | da2[8];
      end
      default: res_out = a_in;
    endcase
  end
endmodule // cad_alu

// >>> cad_core.sv
// Arithmetic group decode, execution and operand addressing of the core
`timescale 1ns/1ps
// Functional notes
// [RULE1] One instruction cycle per 0.75 us machine cycle
// [RULE2] Fetch one, two or three instruction bytes
// [RULE3] Destination doubles as first source, written back
// [RULE4] Working registers from four banks, plus SFR operands
// [RULE5] Direct addressing: low RAM and SFR space
// [RULE6] Bit addressing: RAM bit area, SFR bits
// [RULE7] Indirect via pointer registers or data pointer
// [RULE8] Table read at data pointer or PC plus accumulator
// [RULE9] Destinations only register, direct or indirect forms
// [RULE10] Carry, overflow, auxiliary carry updated per instruction
// [RULE11] Writes to status word byte or bits change flags
// [RULE12] Add family opcodes, one cycle each
// [RULE13] Add with carry family adds carry flag
// [RULE14] Subtract with borrow family subtracts operand, carry
// [RULE15] Increment opcodes 04 to 07 and row 0
// [RULE16] Decrement opcodes 14 to 17 and row 1
// [RULE17] Data pointer increment A3, two cycles, carry
// [RULE18] Multiply A4, divide 84, four cycles each
// [RULE19] Decimal adjust D4 corrects packed BCD sum
module cad_core #(
  parameter int MC_CLKS = cad_pkg::MC_CYCLE_CLKS
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  output logic [15:0]      code_addr_out,
  output logic             code_rd_out,
  input  wire logic [7:0]  code_data_in,
  output logic [15:0]      xdata_addr_out,
  output logic             xdata_rd_out,
  input  wire logic [7:0]  xdata_in,
  output logic [7:0]       acc_out,
  output logic [7:0]       b_out,
  output logic [7:0]       psw_out,
  output logic [7:0]       sp_out,
  output logic [15:0]      data_pointer_out,
  output logic [15:0]      pc_out,
  output logic             done_out
);
  localparam int MCW = $clog2(MC_CLKS);

  logic [7:0]  iram [0:cad_pkg::IRAM_DEPTH-1];
  logic [7:0]  aux  [0:cad_pkg::IRAM_DEPTH-1];
  cad_pkg::cad_state_t state_reg;
  logic [MCW-1:0] mc_cnt_reg;
  logic [15:0] pc_reg;
  logic [7:0]  opc_reg, byte2_reg, byte3_reg, xfer_reg;
  logic [2:0]  cyc_left_reg;
  logic [7:0]  acc_reg, b_reg, psw_reg, sp_reg, dpl_reg, dph_reg;
  logic [7:0]  acc_next, b_next, psw_next, sp_next, dpl_next, dph_next, psw_flags;
  logic        done_reg, code_rd_reg, xdata_rd_reg;
  logic [15:0] code_addr_reg, xdata_addr_reg;

  function automatic logic [1:0] instr_len(input logic [7:0] op);
    logic [3:0] h;
    logic [3:0] l;
    h = op[7:4];
    l = op[3:0];
    if (op == cad_pkg::OP_MOV_DP)
      instr_len = 2'd3;
    else if ((l == cad_pkg::LO_DIR && (h == cad_pkg::HI_INC || h == cad_pkg::HI_DEC ||
              h == cad_pkg::HI_ADD || h == cad_pkg::HI_ADD_WITH_CARRY || h == cad_pkg::HI_SUBTRACT_WITH_BORROW)) ||
             (l == cad_pkg::LO_IMM && (h == cad_pkg::HI_ADD || h == cad_pkg::HI_ADD_WITH_CARRY ||
              h == cad_pkg::HI_SUBTRACT_WITH_BORROW)) ||
             op == cad_pkg::OP_CLR_BIT || op == cad_pkg::OP_SETB_BIT)
      instr_len = 2'd2;
    else
      instr_len = 2'd1;
  endfunction

  function automatic logic [2:0] instr_cycles(input logic [7:0] op);
    case (op)
      cad_pkg::OP_MUL, cad_pkg::OP_DIV: instr_cycles = 3'd4; // [RULE18]
      cad_pkg::OP_INC_DP, cad_pkg::OP_MOV_DP, cad_pkg::OP_MOVC_DP, cad_pkg::OP_MOVC_PC,
      cad_pkg::OP_MOVX_DP, cad_pkg::OP_MOVX_R0, cad_pkg::OP_MOVX_R1: instr_cycles = 3'd2; // [RULE17]
      default: instr_cycles = 3'd1;
    endcase
  endfunction

  // Unmapped SFR addresses read zero; their owners live elsewhere in the chip
  function automatic logic [7:0] dir_rd(input logic [7:0] a);
    if (!a[7])
      dir_rd = iram[a[6:0]]; // [RULE5]
    else
      case (a)
        cad_pkg::SFR_SP:  dir_rd = sp_reg;
        cad_pkg::SFR_DPL: dir_rd = dpl_reg;
        cad_pkg::SFR_DPH: dir_rd = dph_reg;
        cad_pkg::SFR_PSW: dir_rd = psw_reg;
        cad_pkg::SFR_ACC: dir_rd = acc_reg;
        cad_pkg::SFR_B:   dir_rd = b_reg;
        default:          dir_rd = 8'h00;
      endcase
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    bit_byte = a[7] ? {a[7:3], 3'b000} : (cad_pkg::BIT_RAM_BASE | {4'h0, a[6:3]}); // [RULE6]
  endfunction

  // Decode
  logic [3:0] hi, lo;
  logic [1:0] bank;
  logic [7:0] cur_op, ind_ptr, ind_rd, src, bit_addr, bit_old, bit_mask;
  logic [6:0] reg_idx;
  logic f_reg, f_dir, f_ind, f_imm, is_arith, is_incdec, exec_go, mc_en;

  assign mc_en     = (mc_cnt_reg == MCW'(MC_CLKS - 1)); // [RULE1]
  assign exec_go   = (state_reg == cad_pkg::ST_EXEC);
  assign hi        = opc_reg[7:4];
  assign lo        = opc_reg[3:0];
  assign bank      = psw_reg[cad_pkg::PSW_RS_HI:cad_pkg::PSW_RS_LO];
  assign cur_op    = (state_reg == cad_pkg::ST_OPC) ? code_data_in : opc_reg;
  assign reg_idx   = {2'b00, bank, opc_reg[2:0]}; // [RULE4]
  assign ind_ptr   = iram[{2'b00, bank, 2'b00, cur_op[0]}]; // [RULE7]
  assign ind_rd    = ind_ptr[7] ? aux[ind_ptr[6:0]] : iram[ind_ptr[6:0]]; // [RULE7]
  assign f_reg     = opc_reg[3];
  assign f_dir     = (lo == cad_pkg::LO_DIR);
  assign f_ind     = (lo[3:1] == cad_pkg::LO_IND[3:1]);
  assign f_imm     = (lo == cad_pkg::LO_IMM);
  assign is_arith  = (hi == cad_pkg::HI_ADD || hi == cad_pkg::HI_ADD_WITH_CARRY || hi == cad_pkg::HI_SUBTRACT_WITH_BORROW) &&
                     (f_reg || f_dir || f_ind || f_imm); // [RULE12]
  assign is_incdec = (hi == cad_pkg::HI_INC || hi == cad_pkg::HI_DEC) &&
                     (f_reg || f_dir || f_ind || f_imm); // [RULE15] [RULE16]
  assign bit_addr  = bit_byte(byte2_reg);
  // A process, since the read function looks at state that is not among its arguments
  always_comb begin
    src     = f_reg ? iram[reg_idx] : f_dir ? dir_rd(byte2_reg) :
              f_ind ? ind_rd : byte2_reg;
    bit_old = dir_rd(bit_addr);
  end
  assign bit_mask  = 8'h01 << byte2_reg[2:0];

  // Arithmetic unit
  cad_pkg::cad_alu_t alu_sel;
  logic [7:0] alu_a, alu_b, alu_res, alu_hi;
  logic alu_cy, alu_ov, alu_ac;

  assign alu_sel = is_arith ? (hi == cad_pkg::HI_ADD ? cad_pkg::ALU_ADD :
                               hi == cad_pkg::HI_ADD_WITH_CARRY ? cad_pkg::ALU_ADD_WITH_CARRY : cad_pkg::ALU_SUBTRACT_WITH_BORROW) :
                   is_incdec ? (hi == cad_pkg::HI_INC ? cad_pkg::ALU_INC : cad_pkg::ALU_DEC) :
                   opc_reg == cad_pkg::OP_MUL ? cad_pkg::ALU_MUL :
                   opc_reg == cad_pkg::OP_DIV ? cad_pkg::ALU_DIV : cad_pkg::ALU_DA;
  assign alu_a   = (is_incdec && !f_imm) ? src : acc_reg; // [RULE3]
  assign alu_b   = (opc_reg == cad_pkg::OP_MUL || opc_reg == cad_pkg::OP_DIV) ? b_reg : src;

  cad_alu u_alu (
    .sel_in  (alu_sel),
    .a_in    (alu_a),
    .opd_in  (alu_b),
    .cy_in   (psw_reg[cad_pkg::PSW_CY]),
    .ac_in   (psw_reg[cad_pkg::PSW_AC]),
    .res_out (alu_res),
    .hi_out  (alu_hi),
    .cy_out  (alu_cy),
    .ov_out  (alu_ov),
    .ac_out  (alu_ac)
  );

  // Execute
  logic acc_wr, b_wr, cy_wr, ov_wr, ac_wr, dp_wr, mem_we, mem_ind, cy_val;
  logic [7:0] acc_val, mem_addr, mem_wdata;
  logic [15:0] dp_val;

  always_comb begin
    acc_wr = 1'b0; acc_val = alu_res; b_wr = 1'b0;
    cy_wr = 1'b0; cy_val = alu_cy; ov_wr = 1'b0; ac_wr = 1'b0;
    dp_wr = 1'b0; dp_val = {dph_reg, dpl_reg} + 16'h0001; // [RULE17]
    mem_we = 1'b0; mem_ind = 1'b0; mem_addr = byte2_reg; mem_wdata = alu_res;
    if (is_arith) begin
      acc_wr = 1'b1; // [RULE3]
      cy_wr = 1'b1; ov_wr = 1'b1; ac_wr = 1'b1; // [RULE10]
    end else if (is_incdec) begin
      // Only register, direct and indirect forms take a memory result
      if (f_imm) acc_wr = 1'b1; // [RULE9]
      else begin
        mem_we  = 1'b1;
        mem_ind = f_ind;
        mem_addr = f_reg ? {1'b0, reg_idx} : f_ind ? ind_ptr : byte2_reg; // [RULE9]
      end
    end else
      case (opc_reg)
        cad_pkg::OP_MUL, cad_pkg::OP_DIV: begin
          acc_wr = 1'b1; b_wr = 1'b1; cy_wr = 1'b1; ov_wr = 1'b1; // [RULE18] [RULE10]
        end
        cad_pkg::OP_DA: begin acc_wr = 1'b1; cy_wr = 1'b1; end // [RULE19]
        cad_pkg::OP_INC_DP: dp_wr = 1'b1;
        cad_pkg::OP_MOV_DP: begin dp_wr = 1'b1; dp_val = {byte2_reg, byte3_reg}; end
        cad_pkg::OP_MOVC_DP, cad_pkg::OP_MOVC_PC, cad_pkg::OP_MOVX_DP,
        cad_pkg::OP_MOVX_R0, cad_pkg::OP_MOVX_R1: begin acc_wr = 1'b1; acc_val = xfer_reg; end
        cad_pkg::OP_CLR_C:  begin cy_wr = 1'b1; cy_val = 1'b0; end // [RULE10]
        cad_pkg::OP_SETB_C: begin cy_wr = 1'b1; cy_val = 1'b1; end
        cad_pkg::OP_CPL_C:  begin cy_wr = 1'b1; cy_val = ~psw_reg[cad_pkg::PSW_CY]; end
        cad_pkg::OP_RLC: begin
          acc_wr = 1'b1; acc_val = {acc_reg[6:0], psw_reg[cad_pkg::PSW_CY]};
          cy_wr = 1'b1; cy_val = acc_reg[7];
        end
        cad_pkg::OP_RRC: begin
          acc_wr = 1'b1; acc_val = {psw_reg[cad_pkg::PSW_CY], acc_reg[7:1]};
          cy_wr = 1'b1; cy_val = acc_reg[0];
        end
        cad_pkg::OP_CLR_BIT, cad_pkg::OP_SETB_BIT: begin
          mem_we = 1'b1; mem_addr = bit_addr; // [RULE6]
          mem_wdata = opc_reg[4] ? (bit_old | bit_mask) : (bit_old & ~bit_mask);
        end
        default: acc_wr = 1'b0;
      endcase
  end

  function automatic logic sfr_hit(input logic [7:0] a);
    sfr_hit = exec_go && mem_we && !mem_ind && (mem_addr == a);
  endfunction

  always_comb begin
    psw_flags = psw_reg;
    if (exec_go && cy_wr) psw_flags[cad_pkg::PSW_CY] = cy_val;
    if (exec_go && ov_wr) psw_flags[cad_pkg::PSW_OV] = alu_ov;
    if (exec_go && ac_wr) psw_flags[cad_pkg::PSW_AC] = alu_ac;
  end

  // Parity follows the accumulator on every clock; a process so the hit function re-evaluates
  always_comb begin
    acc_next = sfr_hit(cad_pkg::SFR_ACC) ? mem_wdata : (exec_go && acc_wr) ? acc_val : acc_reg;
    b_next   = sfr_hit(cad_pkg::SFR_B) ? mem_wdata : (exec_go && b_wr) ? alu_hi : b_reg;
    sp_next  = sfr_hit(cad_pkg::SFR_SP) ? mem_wdata : sp_reg;
    dpl_next = sfr_hit(cad_pkg::SFR_DPL) ? mem_wdata :
               (exec_go && dp_wr) ? dp_val[7:0] : dpl_reg;
    dph_next = sfr_hit(cad_pkg::SFR_DPH) ? mem_wdata :
               (exec_go && dp_wr) ? dp_val[15:8] : dph_reg;
    psw_next = {sfr_hit(cad_pkg::SFR_PSW) ? mem_wdata[7:1] : psw_flags[7:1], ^acc_next}; // [RULE11]
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      acc_reg <= cad_pkg::ACC_RST; b_reg <= cad_pkg::B_RST; psw_reg <= cad_pkg::PSW_RST;
      sp_reg <= cad_pkg::SP_RST; dpl_reg <= cad_pkg::DPL_RST; dph_reg <= cad_pkg::DPH_RST;
    end else begin
      acc_reg <= acc_next; b_reg <= b_next; psw_reg <= psw_next;
      sp_reg <= sp_next; dpl_reg <= dpl_next; dph_reg <= dph_next;
    end
  end

  // RAM keeps its contents through reset
  always_ff @(posedge mclk_in) begin
    if (exec_go && mem_we && mem_ind && mem_addr[7]) aux[mem_addr[6:0]] <= mem_wdata; // [RULE7]
    else if (exec_go && mem_we && !mem_addr[7]) iram[mem_addr[6:0]] <= mem_wdata; // [RULE5]
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || mc_en) mc_cnt_reg <= '0;
    else mc_cnt_reg <= mc_cnt_reg + MCW'(1);
  end

  // Fetch and sequencing; fetch must finish within the first machine cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= cad_pkg::ST_IDLE; pc_reg <= 16'h0000; cyc_left_reg <= 3'd0;
      code_addr_reg <= 16'h0000; code_rd_reg <= 1'b0; done_reg <= 1'b0;
      xdata_addr_reg <= 16'h0000; xdata_rd_reg <= 1'b0;
      opc_reg <= 8'h00; byte2_reg <= 8'h00; byte3_reg <= 8'h00; xfer_reg <= 8'h00;
    end else begin
      done_reg <= exec_go;
      case (state_reg)
        cad_pkg::ST_IDLE: if (mc_en) begin
          code_addr_reg <= pc_reg; code_rd_reg <= 1'b1; state_reg <= cad_pkg::ST_OPC;
        end
        cad_pkg::ST_OPC: begin
          opc_reg <= code_data_in; pc_reg <= pc_reg + 16'h0001; // [RULE2]
          cyc_left_reg <= instr_cycles(code_data_in);
          if (instr_len(code_data_in) != 2'd1) begin
            code_addr_reg <= pc_reg + 16'h0001; state_reg <= cad_pkg::ST_B2;
          end else if (code_data_in == cad_pkg::OP_MOVC_DP || code_data_in == cad_pkg::OP_MOVC_PC) begin
            code_addr_reg <= (code_data_in == cad_pkg::OP_MOVC_DP ? {dph_reg, dpl_reg} :
                              pc_reg + 16'h0001) + {8'h00, acc_reg}; // [RULE8]
            state_reg <= cad_pkg::ST_XFER;
          end else if (code_data_in == cad_pkg::OP_MOVX_DP || code_data_in == cad_pkg::OP_MOVX_R0 ||
                       code_data_in == cad_pkg::OP_MOVX_R1) begin
            code_rd_reg <= 1'b0; xdata_rd_reg <= 1'b1; state_reg <= cad_pkg::ST_XFER;
            xdata_addr_reg <= code_data_in[1] ? {8'h00, ind_ptr} : {dph_reg, dpl_reg}; // [RULE7]
          end else begin
            code_rd_reg <= 1'b0; state_reg <= cad_pkg::ST_WAIT;
          end
        end
        cad_pkg::ST_B2: begin
          byte2_reg <= code_data_in; pc_reg <= pc_reg + 16'h0001; // [RULE2]
          if (instr_len(opc_reg) == 2'd3) begin
            code_addr_reg <= pc_reg + 16'h0001; state_reg <= cad_pkg::ST_B3;
          end else begin
            code_rd_reg <= 1'b0; state_reg <= cad_pkg::ST_WAIT;
          end
        end
        cad_pkg::ST_B3: begin
          byte3_reg <= code_data_in; pc_reg <= pc_reg + 16'h0001;
          code_rd_reg <= 1'b0; state_reg <= cad_pkg::ST_WAIT;
        end
        cad_pkg::ST_XFER: begin
          xfer_reg <= code_rd_reg ? code_data_in : xdata_in; // [RULE8]
          code_rd_reg <= 1'b0; xdata_rd_reg <= 1'b0; state_reg <= cad_pkg::ST_WAIT;
        end
        cad_pkg::ST_WAIT: if (mc_en) begin
          if (cyc_left_reg == 3'd1) state_reg <= cad_pkg::ST_EXEC; // [RULE1]
          else cyc_left_reg <= cyc_left_reg - 3'd1;
        end
        cad_pkg::ST_EXEC: begin
          code_addr_reg <= pc_reg; code_rd_reg <= 1'b1; state_reg <= cad_pkg::ST_OPC;
        end
        default: state_reg <= cad_pkg::ST_IDLE;
      endcase
    end
  end

  assign code_addr_out = code_addr_reg;
  assign code_rd_out = code_rd_reg;
  assign xdata_addr_out = xdata_addr_reg;
  assign xdata_rd_out = xdata_rd_reg;
  assign acc_out = acc_reg;
  assign b_out = b_reg;
  assign psw_out = psw_reg;
  assign sp_out = sp_reg;
  assign data_pointer_out = {dph_reg, dpl_reg};
  assign pc_out = pc_reg;
  assign done_out = done_reg;

  // Checks
  logic [15:0] gap_cnt_reg;
  logic        seen_exec_reg;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin gap_cnt_reg <= 16'h0000; seen_exec_reg <= 1'b0; end
    else begin
      gap_cnt_reg <= exec_go ? 16'h0000 : gap_cnt_reg + 16'h0001;
      if (exec_go) seen_exec_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_long_fetch;
    state_reg == cad_pkg::ST_B2 ##1 state_reg == cad_pkg::ST_B3 ##1 state_reg == cad_pkg::ST_WAIT;
  endsequence

  chk_mc_period: assert property (mc_en |-> ##MC_CLKS mc_en) // [RULE1]
    else $error("machine cycle enable period wrong");
  chk_fetch_three: assert property ((state_reg == cad_pkg::ST_OPC && // [RULE2]
      code_data_in == cad_pkg::OP_MOV_DP) |=> s_long_fetch)
    else $error("three byte fetch sequence wrong");
  chk_cycle_count: assert property ((exec_go && seen_exec_reg) |-> // [RULE18]
      gap_cnt_reg == 16'(int'(instr_cycles(opc_reg)) * MC_CLKS - 1))
    else $error("instruction length in machine cycles wrong");
  chk_add_imm: assert property ((exec_go && opc_reg == {cad_pkg::HI_ADD, cad_pkg::LO_IMM}) |=> // [RULE12]
      acc_reg == 8'($past(acc_reg) + $past(byte2_reg)))
    else $error("add immediate result wrong");
  chk_add_with_carry_imm: assert property ((exec_go && opc_reg == {cad_pkg::HI_ADD_WITH_CARRY, cad_pkg::LO_IMM}) |=> // [RULE13]
      acc_reg == 8'($past(acc_reg) + $past(byte2_reg) + {7'h00, $past(psw_reg[cad_pkg::PSW_CY])}))
    else $error("add with carry result wrong");
  chk_subtract_with_borrow_imm: assert property ((exec_go && opc_reg == {cad_pkg::HI_SUBTRACT_WITH_BORROW, cad_pkg::LO_IMM}) |=> // [RULE14]
      acc_reg == 8'($past(acc_reg) - $past(byte2_reg) - {7'h00, $past(psw_reg[cad_pkg::PSW_CY])}))
    else $error("subtract with borrow result wrong");
  chk_mul_flags: assert property ((exec_go && opc_reg == cad_pkg::OP_MUL) |=> // [RULE10]
      !psw_reg[cad_pkg::PSW_CY] && (psw_reg[cad_pkg::PSW_OV] == (b_reg != 8'h00)))
    else $error("multiply flags wrong");
  chk_data_pointer_inc: assert property ((exec_go && opc_reg == cad_pkg::OP_INC_DP) |=> // [RULE17]
      {dph_reg, dpl_reg} == 16'($past({dph_reg, dpl_reg}) + 16'h0001))
    else $error("data pointer increment wrong");
  chk_dec_acc: assert property ((exec_go && opc_reg == {cad_pkg::HI_DEC, cad_pkg::LO_IMM}) |=> // [RULE16]
      acc_reg == 8'($past(acc_reg) - 8'h01) && $stable(psw_reg[7:1]))
    else $error("decrement accumulator wrong");
  chk_psw_write: assert property (sfr_hit(cad_pkg::SFR_PSW) |=> // [RULE11]
      psw_reg[7:1] == $past(mem_wdata[7:1]))
    else $error("status word write lost");
endmodule // cad_core

// >>> cad_mem_model.sv
// Program and external data memory model facing the core
`timescale 1ns/1ps
module cad_mem_model (
  input  wire logic [15:0] code_addr_in,
  input  wire logic        code_rd_in,
  output logic [7:0]       code_data_out,
  input  wire logic [15:0] xdata_addr_in,
  input  wire logic        xdata_rd_in,
  output logic [7:0]       xdata_out
);
  logic [7:0] rom [0:255];
  initial begin
    for (int i = 0; i < 256; i++) rom[i] = 8'h00;
  end
  // Idle code bus shows inverted data and idle data bus the inverted address, so a sample taken without the strobe is caught
  assign code_data_out = code_rd_in ? rom[code_addr_in[7:0]] : ~rom[code_addr_in[7:0]];
  assign xdata_out = xdata_rd_in ? (xdata_addr_in[7:0] ^ 8'h5a) : ~xdata_addr_in[7:0];
endmodule // cad_mem_model

// >>> cad_pkg.sv
// Constants, encodings and types for the arithmetic decode and addressing core
package cad_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MACH_CYCLE_NS  = 750;
  localparam int MC_CYCLE_CLKS  = MACH_CYCLE_NS / CLK_PERIOD_NS;
  localparam int IRAM_DEPTH     = 128;

  localparam logic [7:0] SFR_SP  = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B   = 8'hf0;

  localparam logic [7:0] SP_RST  = 8'h07;
  localparam logic [7:0] DPL_RST = 8'h00;
  localparam logic [7:0] DPH_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST   = 8'h00;

  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_RS_HI = 4;

  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  localparam logic [3:0] HI_INC  = 4'h0;
  localparam logic [3:0] HI_DEC  = 4'h1;
  localparam logic [3:0] HI_ADD  = 4'h2;
  localparam logic [3:0] HI_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] HI_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] LO_IMM  = 4'h4;
  localparam logic [3:0] LO_DIR  = 4'h5;
  localparam logic [3:0] LO_IND  = 4'h6;

  localparam logic [7:0] OP_INC_DP  = 8'ha3;
  localparam logic [7:0] OP_MUL     = 8'ha4;
  localparam logic [7:0] OP_DIV     = 8'h84;
  localparam logic [7:0] OP_DA      = 8'hd4;
  localparam logic [7:0] OP_MOV_DP  = 8'h90;
  localparam logic [7:0] OP_MOVC_DP = 8'h93;
  localparam logic [7:0] OP_MOVC_PC = 8'h83;
  localparam logic [7:0] OP_MOVX_DP = 8'he0;
  localparam logic [7:0] OP_MOVX_R0 = 8'he2;
  localparam logic [7:0] OP_MOVX_R1 = 8'he3;
  localparam logic [7:0] OP_CLR_C   = 8'hc3;
  localparam logic [7:0] OP_SETB_C  = 8'hd3;
  localparam logic [7:0] OP_CPL_C   = 8'hb3;
  localparam logic [7:0] OP_CLR_BIT = 8'hc2;
  localparam logic [7:0] OP_SETB_BIT = 8'hd2;
  localparam logic [7:0] OP_RLC     = 8'h33;
  localparam logic [7:0] OP_RRC     = 8'h13;

  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] DA_LO   = 9'h006;
  localparam logic [8:0] DA_HI   = 9'h060;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000, ALU_ADD_WITH_CARRY = 3'b001, ALU_SUBTRACT_WITH_BORROW = 3'b010, ALU_INC = 3'b011,
    ALU_DEC = 3'b100, ALU_MUL = 3'b101, ALU_DIV = 3'b110, ALU_DA = 3'b111
  } cad_alu_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_OPC = 3'b001, ST_B2 = 3'b010, ST_B3 = 3'b011,
    ST_XFER = 3'b100, ST_WAIT = 3'b101, ST_EXEC = 3'b110
  } cad_state_t;
endpackage

// >>> testbench.sv
// Self-checking bench for the arithmetic core with its memory model
`timescale 1ns/1ps
module testbench;
  localparam int MC = 8;
  localparam logic [7:0] PROG [0:22] = '{8'h24, 8'h99, 8'h24, 8'h88, 8'hd4, 8'h34, 8'h10,
    8'h94, 8'h99, 8'h04, 8'h14, 8'h90, 8'h12, 8'hff, 8'ha3, 8'h84, 8'ha4, 8'h93, 8'he0,
    8'h15, 8'hd0, 8'hd2, 8'hd7};
  logic        mclk_in, reset_in, code_rd_out, xdata_rd_out, done_out;
  logic [7:0]  code_data_in, xdata_in, acc_out, b_out, psw_out, sp_out;
  logic [15:0] code_addr_out, xdata_addr_out, data_pointer_out, pc_out;
  int          miscompares, compares;
  cad_core #(.MC_CLKS(MC)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .code_addr_out(code_addr_out), .code_rd_out(code_rd_out), .code_data_in(code_data_in),
    .xdata_addr_out(xdata_addr_out), .xdata_rd_out(xdata_rd_out), .xdata_in(xdata_in),
    .acc_out(acc_out), .b_out(b_out), .psw_out(psw_out), .sp_out(sp_out),
    .data_pointer_out(data_pointer_out), .pc_out(pc_out), .done_out(done_out));
  cad_mem_model mem (.code_addr_in(code_addr_out), .code_rd_in(code_rd_out),
    .code_data_out(code_data_in), .xdata_addr_in(xdata_addr_out),
    .xdata_rd_in(xdata_rd_out), .xdata_out(xdata_in));
  always #5 mclk_in = ~mclk_in;
  task end_of_test;
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Gap since the previous commit pulse tells the machine-cycle count
  task step(input int cyc, input logic [15:0] pc, input logic [7:0] acc, input logic [7:0] program_status_word);
    int n;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (done_out !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      end_of_test();
    end
    if (cyc > 0) chk(16'(n), 16'(cyc * MC));
    chk(pc_out, pc);
    chk({8'h00, acc_out}, {8'h00, acc});
    chk({8'h00, psw_out}, {8'h00, program_status_word});
  endtask
  task sc_add;
    step(0, 16'h0002, 8'h99, 8'h00);
    step(1, 16'h0004, 8'h21, 8'hc4);
  endtask
  task sc_bcd_carry;
    step(1, 16'h0005, 8'h87, 8'hc4);
    step(1, 16'h0007, 8'h98, 8'h01);
    step(1, 16'h0009, 8'hff, 8'hc0);
  endtask
  task sc_inc_dec;
    step(1, 16'h000a, 8'h00, 8'hc0);
    step(1, 16'h000b, 8'hff, 8'hc0);
  endtask
  task sc_pointer;
    step(2, 16'h000e, 8'hff, 8'hc0);
    chk(data_pointer_out, 16'h12ff);
    step(2, 16'h000f, 8'hff, 8'hc0);
    chk(data_pointer_out, 16'h1300);
  endtask
  task sc_mul_div;
    // Divide by zero first, so the multiply sees a known pair
    step(4, 16'h0010, 8'hff, 8'h44);
    step(4, 16'h0011, 8'h00, 8'h40);
    chk({8'h00, b_out}, 16'h0000);
  endtask
  task sc_tables;
    step(2, 16'h0012, 8'h24, 8'h40);
    step(2, 16'h0013, 8'h5a, 8'h40);
  endtask
  // Status word reached as a direct byte, then as a bit; also moves to bank 3
  task sc_status_word;
    step(1, 16'h0015, 8'h5a, 8'h3e);
    step(1, 16'h0017, 8'h5a, 8'hbe);
  endtask
  initial begin
    mclk_in = 1'b0;
    reset_in = 1'b1;
    miscompares = 0;
    compares = 0;
    #1;
    for (int i = 0; i < 23; i++) mem.rom[i] = PROG[i];
    repeat (8) @(negedge mclk_in);
    reset_in = 1'b0;
    chk({8'h00, sp_out}, 16'h0007);
    chk(data_pointer_out, 16'h0000);
    sc_add();
    sc_bcd_carry();
    sc_inc_dec();
    sc_pointer();
    sc_mul_div();
    sc_tables();
    sc_status_word();
    end_of_test();
  end
endmodule // testbench
